// ### rtl/csrw_pkg.sv
/*
 Constants, field layout and types for the channel status readback bank.
 Assumes one 100 MHz clock and a simple strobe register port.
*/
package csrw_pkg;

  // ==========================================================
  // Sizes
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 24;
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned IRQ_W = 2;

  // ==========================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] ADR_CH0 = 4'h0;
  localparam logic [ADDR_W-1:0] ADR_CH3 = 4'h3;
  localparam logic [ADDR_W-1:0] ADR_SYSCTL = 4'h4;
  localparam logic [ADDR_W-1:0] ADR_IRQ_STAT = 4'h5;
  localparam logic [ADDR_W-1:0] ADR_IRQ_MASK = 4'h6;

  // ==========================================================
  // Field positions of the channel word
  localparam int ACC_HI = 23;
  localparam int ACC_LO = 22;
  localparam int CH_ON = 21;
  localparam int DRV_HI = 20;
  localparam int DRV_LO = 19;
  localparam int RSV_BIT = 18;
  localparam int RNG_HI = 17;
  localparam int RNG_LO = 15;
  localparam int SNS_HI = 14;
  localparam int SNS_LO = 13;
  localparam int DIN_BIT = 12;
  localparam int SDL_BIT = 11;
  localparam int SSL_BIT = 10;
  localparam int LIM_BIT = 9;
  localparam int CMP_BIT = 8;
  localparam int CMPV_BIT = 7;
  localparam int TA_STK = 6;
  localparam int TA_LIVE = 5;
  localparam int UNU_HI = 4;
  localparam int TA_CLR = 6;
  localparam logic [1:0] ACC_CHAN = 2'h0;

  // Global control: channel select mask and the two shared enables.
  localparam int SYS_SEL_HI = 3;
  localparam int SYS_LIM = 9;
  localparam int SYS_CMP = 8;

  // Interrupt status bits.
  localparam int IRQ_TA_ON = 0;
  localparam int IRQ_TA_OFF = 1;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    DRV_VOLTAGE = 2'h0,
    DRV_CURRENT = 2'h1,
    DRV_HIZ_V = 2'h2,
    DRV_HIZ_I = 2'h3
  } csrw_drive_t;

  typedef enum logic [1:0] {
    SNS_CURRENT = 2'h0,
    SNS_VOLTAGE = 2'h1,
    SNS_TEMP = 2'h2,
    SNS_HIZ = 2'h3
  } csrw_sense_t;

  typedef struct packed {
    logic channel_on_flag;
    csrw_drive_t drive_select;
    logic [2:0] range_code;
    csrw_sense_t sense_route;
    logic drive_input_source;
    logic shared_drive_link;
    logic shared_sense_link;
    logic limit_on_flag;
    logic comparator_output_on;
    logic compare_voltage;
  } csrw_cfg_t;

  localparam csrw_cfg_t CFG_RST = '{
    channel_on_flag: 1'h0,
    drive_select: DRV_HIZ_V,
    range_code: 3'h0,
    sense_route: SNS_HIZ,
    drive_input_source: 1'h0,
    shared_drive_link: 1'h0,
    shared_sense_link: 1'h0,
    limit_on_flag: 1'h0,
    comparator_output_on: 1'h0,
    compare_voltage: 1'h0
  };

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } csrw_req_t;

endpackage : csrw_pkg

// ### rtl/csrw_channel_status.sv
/*
 Channel configuration store and 24-bit status readback word for four
 measurement channels, with the device-wide thermal alarm.
 Assumes all inputs are synchronous to i_ref_clk and a master that never
 raises both strobes in one cycle.
*/
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps

module csrw_channel_status (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [csrw_pkg::ADDR_W-1:0] i_addr,
  input wire logic [csrw_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [csrw_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_over_temp,
  output logic o_tmp_alarm_o,
  output logic o_tmp_alarm_oe,
  output logic o_irq,
  output csrw_pkg::csrw_cfg_t [csrw_pkg::NUM_CH-1:0] o_ch_cfg
);

  // ==========================================================
  // Functions

  // Unpacks a channel write into configuration fields.
  function automatic csrw_pkg::csrw_cfg_t cfg_from_word(
    input logic [csrw_pkg::DATA_W-1:0] w
  );
    csrw_pkg::csrw_cfg_t c;
    c.channel_on_flag = w[csrw_pkg::CH_ON];
    c.drive_select =
      csrw_pkg::csrw_drive_t'(w[csrw_pkg::DRV_HI:csrw_pkg::DRV_LO]);
    c.range_code = w[csrw_pkg::RNG_HI:csrw_pkg::RNG_LO];
    c.sense_route =
      csrw_pkg::csrw_sense_t'(w[csrw_pkg::SNS_HI:csrw_pkg::SNS_LO]);
    c.drive_input_source = w[csrw_pkg::DIN_BIT];
    c.shared_drive_link = w[csrw_pkg::SDL_BIT];
    c.shared_sense_link = w[csrw_pkg::SSL_BIT];
    c.limit_on_flag = w[csrw_pkg::LIM_BIT];
    c.comparator_output_on = w[csrw_pkg::CMP_BIT];
    c.compare_voltage = w[csrw_pkg::CMPV_BIT];
    return c;
  endfunction : cfg_from_word

  // Packs one channel's fields and the thermal bits into a word.
  function automatic logic [csrw_pkg::DATA_W-1:0] word_from_cfg(
    input csrw_pkg::csrw_cfg_t c,
    input logic stk,
    input logic live
  );
    logic [csrw_pkg::DATA_W-1:0] w;
    w = '0;
    w[csrw_pkg::ACC_HI:csrw_pkg::ACC_LO] = csrw_pkg::ACC_CHAN;
    w[csrw_pkg::CH_ON] = c.channel_on_flag;
    w[csrw_pkg::DRV_HI:csrw_pkg::DRV_LO] = c.drive_select;
    w[csrw_pkg::RNG_HI:csrw_pkg::RNG_LO] = c.range_code;
    w[csrw_pkg::SNS_HI:csrw_pkg::SNS_LO] = c.sense_route;
    w[csrw_pkg::DIN_BIT] = c.drive_input_source;
    w[csrw_pkg::SDL_BIT] = c.shared_drive_link;
    w[csrw_pkg::SSL_BIT] = c.shared_sense_link;
    w[csrw_pkg::LIM_BIT] = c.limit_on_flag;
    w[csrw_pkg::CMP_BIT] = c.comparator_output_on;
    w[csrw_pkg::CMPV_BIT] = c.compare_voltage;
    w[csrw_pkg::TA_STK] = stk;
    w[csrw_pkg::TA_LIVE] = live;
    return w;
  endfunction : word_from_cfg

  // ==========================================================
  // Address decode

  logic [csrw_pkg::NUM_CH-1:0] wr_ch;
  logic wr_sys;
  logic wr_stat;
  logic wr_mask;
  logic clr_req;
  logic [1:0] ch_idx;
  logic ch_hit;

  // Channel window is ADR_CH0 to ADR_CH3; the low bits pick the channel.
  assign ch_hit = (i_addr >= csrw_pkg::ADR_CH0)
    && (i_addr <= csrw_pkg::ADR_CH3);
  assign ch_idx = i_addr[1:0];

  // Write strobes for each register.
  always_comb begin
    wr_ch = '0;
    if (i_wr && ch_hit) begin
      wr_ch[ch_idx] = 1'b1;
    end
    wr_sys = i_wr && (i_addr == csrw_pkg::ADR_SYSCTL);
    wr_stat = i_wr && (i_addr == csrw_pkg::ADR_IRQ_STAT);
    wr_mask = i_wr && (i_addr == csrw_pkg::ADR_IRQ_MASK);
    clr_req = i_wr && ch_hit && i_wdata[csrw_pkg::TA_CLR];
  end

  // ==========================================================
  // Channel configuration store

  csrw_pkg::csrw_cfg_t [csrw_pkg::NUM_CH-1:0] cfg_r;
  csrw_pkg::csrw_cfg_t [csrw_pkg::NUM_CH-1:0] cfg_nxt;

  // A channel write loads every field; a global write touches only the
  // clamp and comparator enables of the channels it selects. Both share
  // one storage bit per channel, so the later write wins.
  always_comb begin
    cfg_nxt = cfg_r;
    for (int n = 0; n < csrw_pkg::NUM_CH; n++) begin
      if (wr_ch[n]) begin
        cfg_nxt[n] = cfg_from_word(i_wdata);
      end else if (wr_sys && i_wdata[n]) begin
        cfg_nxt[n].limit_on_flag = i_wdata[csrw_pkg::SYS_LIM];
        cfg_nxt[n].comparator_output_on = i_wdata[csrw_pkg::SYS_CMP];
      end
    end
  end

  // Registers the channel configuration.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cfg_r <= {csrw_pkg::NUM_CH{csrw_pkg::CFG_RST}};
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  assign o_ch_cfg = cfg_r;

  // ==========================================================
  // Thermal alarm

  logic live_r;
  logic live_nxt;
  logic stk_r;
  logic stk_nxt;
  logic ta_on;
  logic ta_off;

  // Live bit follows the comparator level; the sticky bit is set by
  // the level and held until cleared. A set in the clearing cycle wins.
  always_comb begin
    live_nxt = i_over_temp;
    stk_nxt = i_over_temp || (stk_r && !clr_req);
    ta_on = i_over_temp && !live_r;
    ta_off = !i_over_temp && live_r;
  end

  // Registers the thermal alarm state.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      live_r <= 1'b0;
      stk_r <= 1'b0;
    end else begin
      live_r <= live_nxt;
      stk_r <= stk_nxt;
    end
  end

  // Open-drain alarm pin pulls low while the sticky alarm is set.
  // pin mirrors sticky bit
  assign o_tmp_alarm_o = 1'b0;
  assign o_tmp_alarm_oe = stk_r;

  // ==========================================================
  // Interrupts

  logic [csrw_pkg::IRQ_W-1:0] irq_stat_r;
  logic [csrw_pkg::IRQ_W-1:0] irq_stat_nxt;
  logic [csrw_pkg::IRQ_W-1:0] irq_mask_r;
  logic [csrw_pkg::IRQ_W-1:0] irq_mask_nxt;
  logic [csrw_pkg::IRQ_W-1:0] irq_set;
  logic [csrw_pkg::IRQ_W-1:0] irq_clr;

  // Alarm onset and recovery set sticky bits; writing one clears them,
  // but an event in the same cycle keeps its bit set.
  always_comb begin
    irq_set = '0;
    irq_set[csrw_pkg::IRQ_TA_ON] = ta_on;
    irq_set[csrw_pkg::IRQ_TA_OFF] = ta_off;
    irq_clr = wr_stat ? i_wdata[csrw_pkg::IRQ_W-1:0] : '0;
    irq_stat_nxt = irq_set | (irq_stat_r & ~irq_clr);
    irq_mask_nxt = wr_mask ? i_wdata[csrw_pkg::IRQ_W-1:0] : irq_mask_r;
  end

  // Registers interrupt status and mask.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
    end
  end

  assign o_irq = |(irq_stat_r & irq_mask_r);

  // ==========================================================
  // Read path

  logic [csrw_pkg::DATA_W-1:0] rdata_r;
  logic [csrw_pkg::DATA_W-1:0] rdata_nxt;

  // Read data stand only in the cycle after the strobe; unmapped
  // addresses and idle cycles return zero.
  always_comb begin
    rdata_nxt = '0;
    if (i_rd) begin
      if (ch_hit) begin
        rdata_nxt = word_from_cfg(cfg_r[ch_idx], stk_r, live_r);
      end else if (i_addr == csrw_pkg::ADR_IRQ_STAT) begin
        rdata_nxt[csrw_pkg::IRQ_W-1:0] = irq_stat_r;
      end else if (i_addr == csrw_pkg::ADR_IRQ_MASK) begin
        rdata_nxt[csrw_pkg::IRQ_W-1:0] = irq_mask_r;
      end
    end
  end

  // Registers the read data.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign o_rdata = rdata_r;

endmodule : csrw_channel_status

// ### dv/csrw_channel_status_checker.sv
/*
 Port assertions for the channel status bank.
 Assumes it is bound to csrw_channel_status.
*/
`timescale 1ns/1ps

module csrw_channel_status_checker (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [csrw_pkg::ADDR_W-1:0] i_addr,
  input wire logic [csrw_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [csrw_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_over_temp,
  input wire logic o_tmp_alarm_o,
  input wire logic o_tmp_alarm_oe,
  input wire logic o_irq,
  input wire csrw_pkg::csrw_cfg_t [csrw_pkg::NUM_CH-1:0] o_ch_cfg
);
  // ==========================================================
  // Helpers: addressed channel held over the read, and clear request.
  csrw_pkg::csrw_cfg_t sel_r;
  logic chan_rd_r;
  logic clr;
  assign clr = i_wr && i_addr <= csrw_pkg::ADR_CH3 && i_wdata[6];
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sel_r <= csrw_pkg::CFG_RST;
      chan_rd_r <= 1'b0;
    end else begin
      sel_r <= o_ch_cfg[i_addr[1:0]];
      chan_rd_r <= i_rd && i_addr <= csrw_pkg::ADR_CH3;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == '0)
    else $error("read data not zero outside a read");
  prefix_zero_a: assert property (o_rdata[23:22] == 2'h0)
    else $error("access prefix not zero");
  pad_zero_a: assert property (!o_rdata[18]
    && (!chan_rd_r || o_rdata[4:0] == 5'h0))
    else $error("reserved bits not zero");
  mode_echo_a: assert property (chan_rd_r |->
    o_rdata[21:19] == sel_r[13:11]) else $error("enable or mode wrong");
  field_echo_a: assert property (chan_rd_r |->
    o_rdata[17:7] == sel_r[10:0]) else $error("channel fields wrong");
  live_echo_a: assert property (chan_rd_r |->
    o_rdata[5] == $past(i_over_temp, 2)) else $error("live alarm wrong");
  stk_echo_a: assert property (chan_rd_r |->
    o_rdata[6] == $past(o_tmp_alarm_oe)) else $error("sticky bit wrong");
  stk_set_a: assert property (i_over_temp |=> o_tmp_alarm_oe)
    else $error("sticky alarm not set");
  stk_hold_a: assert property (o_tmp_alarm_oe && !clr |=>
    o_tmp_alarm_oe) else $error("sticky alarm dropped");
  stk_clear_a: assert property (clr && !i_over_temp |=>
    !o_tmp_alarm_oe) else $error("sticky alarm not cleared");
  od_low_a: assert property (o_tmp_alarm_o == 1'b0)
    else $error("alarm pin data not low");
  sys_lim_a: assert property (i_wr && i_addr == 4'h4 && i_wdata[0]
    |=> o_ch_cfg[0].limit_on_flag == $past(i_wdata[9])
    && o_ch_cfg[0].comparator_output_on == $past(i_wdata[8]))
    else $error("global enable not taken");

  rd_cov_c: cover property (chan_rd_r && o_rdata[6]);
  clr_cov_c: cover property (clr && o_tmp_alarm_oe && !i_over_temp);
  irq_cov_c: cover property (o_irq);
endmodule : csrw_channel_status_checker

// ### dv/csrw_host.sv
/*
 Host model: register master of the status bank.
 Assumes the bank answers a read one cycle later and never stalls.
*/
`timescale 1ns/1ps

module csrw_host (
  input wire logic i_ref_clk,
  output logic [csrw_pkg::ADDR_W-1:0] o_addr,
  output logic [csrw_pkg::DATA_W-1:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  // ==========================================================
  // Bus idles with both strobes low.
  initial begin
    o_addr = 4'h0;
    o_wdata = 24'h0;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  // One-cycle write; data turned over afterwards so stale data is no help.
  task automatic wr(logic [3:0] a, logic [23:0] d);
    @(posedge i_ref_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_ref_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
  endtask : wr

  task automatic rd(logic [3:0] a);
    @(posedge i_ref_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_ref_clk);
    o_rd <= 1'b0;
  endtask : rd
endmodule : csrw_host

// ### dv/csrw_channel_status_bench.sv
/*
 Self-checking bench for the channel status bank.
 Assumes the host model drives the register port.
*/
`timescale 1ns/1ps

module csrw_channel_status_bench;
  localparam logic [23:0] FMASK = 24'h3bff80;
  localparam csrw_pkg::csrw_cfg_t RC = csrw_pkg::CFG_RST;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ot = 1'b0;
  logic rd_seen = 1'b0;
  logic [3:0] addr;
  logic [23:0] wdata;
  logic [23:0] rdata;
  logic wr;
  logic rd;
  logic od;
  logic oe;
  logic irq;
  csrw_pkg::csrw_cfg_t [3:0] cfg;
  logic [23:0] expq[$];
  logic [23:0] exp_w[4];
  logic [1:0] al = 2'h0;
  logic [31:0] seed = 32'h1f4a6779;
  logic [31:0] r;
  int n_mismatch = 0;
  int checks_done = 0;

  // ==========================================================
  // Clock and instances.
  always #5 clk = ~clk;

  csrw_host csrw_host_inst (.i_ref_clk(clk), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  csrw_channel_status csrw_channel_status_inst (.i_ref_clk(clk),
    .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_over_temp(ot), .o_tmp_alarm_o(od),
    .o_tmp_alarm_oe(oe), .o_irq(irq), .o_ch_cfg(cfg));

  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic check(string what, logic [23:0] seen, logic [23:0] e);
    checks_done++;
    if (seen !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, e, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  task automatic rd1(logic [3:0] a, logic [23:0] e);
    expq.push_back(e);
    csrw_host_inst.rd(a);
  endtask : rd1

  task automatic rd_all();
    for (int c = 0; c < 4; c++) begin
      rd1(c[3:0], exp_w[c] | {17'h0, al, 5'h0});
    end
  endtask : rd_all

  task automatic wch(logic [1:0] c, logic [23:0] d);
    csrw_host_inst.wr({2'h0, c}, d);
    exp_w[c] = d & FMASK;
  endtask : wch

  task automatic pins(logic [1:0] e);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("alarm_irq", {22'h0, oe, irq}, {22'h0, e});
    // Return on a rising edge so the next input change is launched there.
    @(posedge clk);
  endtask : pins

  // Note each read strobe; compare the answer on the falling edge.
  always @(posedge clk) rd_seen <= rd;
  always @(negedge clk) begin
    if (rd_seen) begin
      if (expq.size() == 0) check("queue", 24'h1, 24'h0);
      else check("rdata", rdata, expq.pop_front());
    end
  end

  // Main sequence: reset words, every code, random writers, alarm.
  initial begin
    for (int c = 0; c < 4; c++) begin
      exp_w[c] = {2'h0, RC[13:11], 1'b0, RC[10:0], 7'h0};
    end
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd_all();
    csrw_host_inst.wr(csrw_pkg::ADR_IRQ_MASK, 24'h0);
    for (int c = 0; c < 4; c++) begin
      r = xs();
      wch(c[1:0], (r[23:0] & ~24'h186000)
        | {3'h0, c[1:0], 4'h0, c[1:0], 13'h0});
    end
    rd_all();
    for (int i = 0; i < 16; i++) begin
      r = xs();
      if (r[31]) begin
        wch(r[25:24], r[23:0]);
      end else begin
        csrw_host_inst.wr(csrw_pkg::ADR_SYSCTL, r[23:0]);
        for (int c = 0; c < 4; c++) begin
          if (r[c]) begin
            exp_w[c][9] = r[9];
            exp_w[c][8] = r[8];
          end
        end
      end
      rd_all();
    end
    rd1(4'h9, 24'h0);
    rd1(csrw_pkg::ADR_SYSCTL, 24'h0);
    pins(2'b00);
    ot <= 1'b1;
    al = 2'h3;
    pins(2'b10);
    rd_all();
    wch(2'h1, exp_w[1] | 24'h40);
    pins(2'b10);
    ot <= 1'b0;
    al = 2'h2;
    pins(2'b10);
    rd_all();
    rd1(csrw_pkg::ADR_IRQ_STAT, 24'h3);
    csrw_host_inst.wr(csrw_pkg::ADR_IRQ_MASK, 24'h3);
    pins(2'b11);
    wch(2'h2, exp_w[2] | 24'h40);
    al = 2'h0;
    pins(2'b01);
    rd_all();
    csrw_host_inst.wr(csrw_pkg::ADR_IRQ_STAT, 24'h3);
    pins(2'b00);
    rd1(csrw_pkg::ADR_IRQ_STAT, 24'h0);
    for (int k = 0; k < 20 && expq.size() > 0; k++) @(posedge clk);
    if (expq.size() > 0) check("drain", 24'h1, 24'h0);
    report_and_stop();
  end
endmodule : csrw_channel_status_bench

bind csrw_channel_status csrw_channel_status_checker
  csrw_channel_status_checker_inst (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_over_temp(i_over_temp),
  .o_tmp_alarm_o(o_tmp_alarm_o), .o_tmp_alarm_oe(o_tmp_alarm_oe),
  .o_irq(o_irq), .o_ch_cfg(o_ch_cfg));
